// ---- rtl/status_diagnostic_monitor.sv ----
// Function
// - self-test failures gather in a 32-bit mask; zero mask means pass
// - downlink loss, receiver reset failure, test byte mismatch set their bits
// - fifo full before 4096 writes or not full after sets its bit
// - boot reject, bad slave count, slave internal failure set separate bits
// - excess round-trip deviation and missing sync each set a bit
// - count answering slaves up to 23 and hold that count
// - measure round-trip delay at boot and offer it for timing compensation
// - receiver link status is one of five codes
// - last reset cause is held as one of eleven sources
// - uptime in days and h:m:s since reset, wrapping near 180 days
// - saved-settings version shown only when it differs from running one
// - inserted-defaults count shown with beep until settings are saved
// - status registers are read-only to the terminal
// - swap command toggles inputs; leaving the monitor restores normal
// - swap refused and hidden when receiver cannot swap
// - examiner delivers every host word at once with running counter
// - examiner sends no reply to host words, host output only on manual write
// - write sends one word per use; quit leaves examiner
// - examiner only from serial terminal, hidden over host session
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
module status_diagnostic_monitor
    import status_diag_pkg::*;
#(
    parameter int DELAY_WIDTH = 16,
    parameter int SECOND_CYCLES = CYCLES_PER_SECOND
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // avalon-mm slave
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // self-test results (pulses from test logic)
    input  wire logic        no_downlink_i,
    input  wire logic        rx_reset_fail_i,
    input  wire logic        test_byte_bad_i,
    input  wire logic        fifo_write_i,
    input  wire logic        fifo_full_i,
    input  wire logic        fifo_test_end_i,
    input  wire logic        boot_reject_i,
    input  wire logic        slave_answer_i,
    input  wire logic        slave_count_done_i,
    input  wire logic        slave_fail_i,
    // round trip
    input  wire logic        rt_start_i,
    input  wire logic        rt_echo_i,
    input  wire logic [7:0]  acq_period_i,
    // receiver status pins
    input  wire logic        downlink_lost_i,
    input  wire logic        uplink_err_i,
    input  wire logic        pll_unlocked_i,
    input  wire logic        test_sw_off_i,
    input  wire logic        swap_capable_i,
    // reset cause and settings
    input  wire logic [3:0]  reset_cause_i,
    input  wire logic [15:0] saved_version_i,
    input  wire logic [15:0] running_version_i,
    input  wire logic [7:0]  defaults_count_i,
    input  wire logic        host_session_i,
    // host word port
    input  wire logic        host_word_valid_i,
    input  wire logic [15:0] host_word_i,
    output logic             host_out_valid_o,
    output logic      [15:0] host_out_word_o,
    // outputs
    output logic             swap_inputs_o,
    output logic             beep_o,
    output logic [DELAY_WIDTH-1:0] rt_delay_o
);
    initial begin
        if (DELAY_WIDTH < 8 || DELAY_WIDTH > 32) $error("bad DELAY_WIDTH");
        if (SECOND_CYCLES < 2) $error("SECOND_CYCLES too small");
    end

    // pin synchronisers (two flops each)
    logic [4:0] pin_s1_reg, pin_s2_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= {swap_capable_i, test_sw_off_i, pll_unlocked_i,
                           uplink_err_i, downlink_lost_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // delay meter
    logic [DELAY_WIDTH-1:0] spread;
    logic                   jit_err, no_sync;
    delay_meter #(.WIDTH(DELAY_WIDTH)) u_meter (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .start_i      (rt_start_i),
        .echo_i       (rt_echo_i),
        .acq_period_i (acq_period_i),
        .delay_o      (rt_delay_o),
        .spread_o     (spread),
        .jitter_err_o (jit_err),
        .no_sync_o    (no_sync),
        .done_o       ()
    );

    // self-test state
    logic [31:0] err_reg, err_next;
    logic [12:0] fifo_cnt_reg, fifo_cnt_next;
    logic [4:0]  slaves_reg, slaves_next;
    logic        slaves_locked_reg, slaves_locked_next;
    logic        slave_over_reg, slave_over_next;

    // error mask next values
    always_comb begin
        err_next           = err_reg;
        fifo_cnt_next      = fifo_cnt_reg;
        slaves_next        = slaves_reg;
        slaves_locked_next = slaves_locked_reg;
        slave_over_next    = slave_over_reg;
        if (no_downlink_i)   err_next = err_next | ERR_NO_DOWNLINK;
        if (rx_reset_fail_i) err_next = err_next | ERR_RESET_REQ;
        if (test_byte_bad_i) err_next = err_next | ERR_TEST_BYTE;
        if (fifo_write_i && fifo_cnt_reg < FIFO_TEST_WRITES) begin
            if (fifo_full_i) err_next = err_next | ERR_FIFO_EARLY;
            fifo_cnt_next = fifo_cnt_reg + 13'h1;
        end
        if (fifo_test_end_i && fifo_cnt_reg == FIFO_TEST_WRITES && !fifo_full_i)
            err_next = err_next | ERR_FIFO_NOT_FULL;
        if (boot_reject_i) err_next = err_next | ERR_BOOT_REJECT;
        if (slave_fail_i)  err_next = err_next | ERR_SLAVE_INTERNAL;
        if (slave_answer_i && !slaves_locked_reg) begin
            if (slaves_reg == MAX_SLAVES) slave_over_next = 1'b1;
            else slaves_next = slaves_reg + 5'h1;
        end
        if (slave_count_done_i && !slaves_locked_reg) begin
            slaves_locked_next = 1'b1;
            if (slave_over_reg || slaves_reg == 5'h0)
                err_next = err_next | ERR_SLAVE_COUNT;
        end
        if (jit_err) err_next = err_next | ERR_JITTER;
        if (no_sync) err_next = err_next | ERR_NO_SYNC;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_reg           <= '0;
            fifo_cnt_reg      <= '0;
            slaves_reg        <= '0;
            slaves_locked_reg <= 1'b0;
            slave_over_reg    <= 1'b0;
        end else begin
            err_reg           <= err_next;
            fifo_cnt_reg      <= fifo_cnt_next;
            slaves_reg        <= slaves_next;
            slaves_locked_reg <= slaves_locked_next;
            slave_over_reg    <= slave_over_next;
        end
    end

    // link status code, priority fixed
    link_code_t link_code;
    always_comb begin
        if (pin_s2_reg[0])      link_code = downlink_fault_code;
        else if (pin_s2_reg[1]) link_code = uplink_fault_code;
        else if (pin_s2_reg[2]) link_code = reference_unlocked_code;
        else if (pin_s2_reg[3]) link_code = test_switch_code;
        else                    link_code = link_okay_code;
    end

    // reset cause captured after release, out-of-range held as power-up
    logic [3:0] cause_reg, cause_next;
    logic       cause_taken_reg, cause_taken_next;
    always_comb begin
        cause_next       = cause_reg;
        cause_taken_next = 1'b1;
        if (!cause_taken_reg) begin
            if (reset_cause_i >= 4'h1 && reset_cause_i <= 4'hb)
                cause_next = reset_cause_i;
            else
                cause_next = cause_power_up;
        end
    end

    // uptime counters
    logic [31:0] tick_reg, tick_next;
    logic [5:0]  sec_reg, sec_next, min_reg, min_next;
    logic [4:0]  hour_reg, hour_next;
    logic [7:0]  day_reg, day_next;
    always_comb begin
        tick_next = tick_reg + 32'h1;
        sec_next  = sec_reg;
        min_next  = min_reg;
        hour_next = hour_reg;
        day_next  = day_reg;
        if (tick_reg == 32'(SECOND_CYCLES - 1)) begin
            tick_next = '0;
            sec_next  = sec_reg + 6'h1;
            if (sec_reg == 6'h3b) begin
                sec_next = '0;
                min_next = min_reg + 6'h1;
                if (min_reg == 6'h3b) begin
                    min_next  = '0;
                    hour_next = hour_reg + 5'h1;
                    if (hour_reg == 5'h17) begin
                        hour_next = '0;
                        day_next  = (day_reg == DAY_WRAP - 8'h1) ? 8'h0
                                                                   : day_reg + 8'h1;
                    end
                end
            end
        end
    end

    // control state: swap, examiner, defaults warning
    logic        swap_reg, swap_next;
    logic        exam_reg, exam_next;
    logic        warn_reg, warn_next;
    logic        beep_reg, beep_next;
    logic [15:0] exam_cnt_reg, exam_cnt_next;
    logic [15:0] exam_word_reg, exam_word_next;
    logic [15:0] line_start_reg, line_start_next;
    logic        exam_new_reg, exam_new_next;
    logic        out_vld_reg, out_vld_next;
    logic [15:0] out_word_reg, out_word_next;
    logic        swap_refused_reg, swap_refused_next;
    logic        ctrl_wr, exam_wr, stat_rd, ack_reg;

    // accesses act once, at the edge that ends the wait
    assign ctrl_wr = ack_reg && avs_write_i && avs_address_i == ADDR_CONTROL;
    assign exam_wr = ack_reg && avs_write_i && avs_address_i == ADDR_EXAM_WRITE;
    assign stat_rd = ack_reg && avs_read_i && avs_address_i == ADDR_EXAM_STATUS;

    always_comb begin
        swap_next         = swap_reg;
        exam_next         = exam_reg;
        warn_next         = warn_reg;
        beep_next         = 1'b0;
        exam_cnt_next     = exam_cnt_reg;
        exam_word_next    = exam_word_reg;
        line_start_next   = line_start_reg;
        exam_new_next     = exam_new_reg;
        out_vld_next      = 1'b0;
        out_word_next     = out_word_reg;
        swap_refused_next = swap_refused_reg;
        if (!cause_taken_reg && defaults_count_i != 8'h0) begin
            warn_next = 1'b1;
            beep_next = 1'b1;
        end
        if (ctrl_wr) begin
            if (avs_writedata_i[CTRL_SWAP_CMD]) begin
                if (pin_s2_reg[4]) swap_next = !swap_reg;
                else swap_refused_next = 1'b1;
            end
            if (avs_writedata_i[CTRL_EXAM_CMD] && !host_session_i) begin
                exam_next       = 1'b1;
                exam_cnt_next   = '0;
                line_start_next = '0;
            end
            if (avs_writedata_i[CTRL_EXAM_QUIT]) exam_next = 1'b0;
            if (avs_writedata_i[CTRL_MON_EXIT]) begin
                swap_next = 1'b0;
                exam_next = 1'b0;
            end
            if (avs_writedata_i[CTRL_SAVE]) warn_next = 1'b0;
        end
        // new line begins at the next word after status is read
        if (stat_rd) line_start_next = exam_cnt_reg;
        if (stat_rd) exam_new_next = 1'b0;
        if (exam_reg && host_word_valid_i) begin
            exam_word_next = host_word_i;
            exam_cnt_next  = exam_cnt_reg + 16'h1;
            exam_new_next  = 1'b1;
        end
        if (exam_reg && exam_wr) begin
            out_vld_next  = 1'b1;
            out_word_next = avs_writedata_i[15:0];
        end
    end

    // state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_reg        <= cause_power_up;
            cause_taken_reg  <= 1'b0;
            tick_reg         <= '0;
            sec_reg          <= '0;
            min_reg          <= '0;
            hour_reg         <= '0;
            day_reg          <= '0;
            swap_reg         <= 1'b0;
            exam_reg         <= 1'b0;
            warn_reg         <= 1'b0;
            beep_reg         <= 1'b0;
            exam_cnt_reg     <= '0;
            exam_word_reg    <= '0;
            line_start_reg   <= '0;
            exam_new_reg     <= 1'b0;
            out_vld_reg      <= 1'b0;
            out_word_reg     <= '0;
            swap_refused_reg <= 1'b0;
        end else begin
            cause_reg        <= cause_next;
            cause_taken_reg  <= cause_taken_next;
            tick_reg         <= tick_next;
            sec_reg          <= sec_next;
            min_reg          <= min_next;
            hour_reg         <= hour_next;
            day_reg          <= day_next;
            swap_reg         <= swap_next;
            exam_reg         <= exam_next;
            warn_reg         <= warn_next;
            beep_reg         <= beep_next;
            exam_cnt_reg     <= exam_cnt_next;
            exam_word_reg    <= exam_word_next;
            line_start_reg   <= line_start_next;
            exam_new_reg     <= exam_new_next;
            out_vld_reg      <= out_vld_next;
            out_word_reg     <= out_word_next;
            swap_refused_reg <= swap_refused_next;
        end
    end

    // read mux; status registers ignore writes
    logic [31:0] rd_next, rd_reg;
    logic        ver_differs;
    assign ver_differs = saved_version_i != running_version_i;
    always_comb begin
        rd_next = '0;
        unique case (avs_address_i)
            ADDR_ERROR_MASK:  rd_next = err_reg;
            ADDR_SUMMARY:     rd_next = {8'h0, warn_reg ? defaults_count_i : 8'h0,
                                         3'h0, slaves_reg, cause_reg,
                                         link_code, err_reg == 32'h0};
            ADDR_DELAY:       rd_next = 32'(rt_delay_o);
            ADDR_JITTER:      rd_next = 32'(spread);
            ADDR_UPTIME_DAYS: rd_next = {24'h0, day_reg};
            ADDR_UPTIME_HMS:  rd_next = {11'h0, hour_reg, 2'h0, min_reg, 2'h0, sec_reg};
            ADDR_CONTROL:     rd_next = {26'h0, !host_session_i, pin_s2_reg[4],
                                         swap_refused_reg, warn_reg, exam_reg,
                                         swap_reg};
            ADDR_EXAM_STATUS: rd_next = {line_start_reg, 15'h0, exam_new_reg};
            ADDR_EXAM_WORD:   rd_next = {exam_cnt_reg, exam_word_reg};
            ADDR_VERSION:     rd_next = ver_differs ? {16'h0, saved_version_i}
                                                    : 32'h0;
            default:          rd_next = '0;
        endcase
    end

    // one wait cycle per access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_reg  <= '0;
            ack_reg <= 1'b0;
        end else begin
            rd_reg  <= rd_next;
            ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
        end
    end

    assign avs_readdata_o    = rd_reg;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
    assign host_out_valid_o  = out_vld_reg;
    assign host_out_word_o   = out_word_reg;
    assign swap_inputs_o     = swap_reg;
    assign beep_o            = beep_reg;
endmodule // status_diagnostic_monitor

// ---- shared/status_diag_pkg.sv ----
package status_diag_pkg;

    // register byte offsets (one 32-bit word each)
    localparam logic [5:0] ADDR_ERROR_MASK  = 6'h00;
    localparam logic [5:0] ADDR_SUMMARY     = 6'h04;
    localparam logic [5:0] ADDR_DELAY       = 6'h08;
    localparam logic [5:0] ADDR_JITTER      = 6'h0c;
    localparam logic [5:0] ADDR_UPTIME_DAYS = 6'h10;
    localparam logic [5:0] ADDR_UPTIME_HMS  = 6'h14;
    localparam logic [5:0] ADDR_CONTROL     = 6'h18;
    localparam logic [5:0] ADDR_EXAM_STATUS = 6'h1c;
    localparam logic [5:0] ADDR_EXAM_WORD   = 6'h20;
    localparam logic [5:0] ADDR_EXAM_WRITE  = 6'h24;
    localparam logic [5:0] ADDR_VERSION     = 6'h28;

    // error mask bit values
    localparam logic [31:0] ERR_NO_DOWNLINK    = 32'h0000_0001;
    localparam logic [31:0] ERR_RESET_REQ      = 32'h0000_0004;
    localparam logic [31:0] ERR_FIFO_EARLY     = 32'h0000_0008;
    localparam logic [31:0] ERR_FIFO_NOT_FULL  = 32'h0000_0010;
    localparam logic [31:0] ERR_TEST_BYTE      = 32'h0000_0100;
    localparam logic [31:0] ERR_BOOT_REJECT    = 32'h0004_0000;
    localparam logic [31:0] ERR_SLAVE_COUNT    = 32'h0010_0000;
    localparam logic [31:0] ERR_SLAVE_INTERNAL = 32'h0040_0000;
    localparam logic [31:0] ERR_JITTER         = 32'h0100_0000;
    localparam logic [31:0] ERR_NO_SYNC        = 32'h0200_0000;

    // fifo test and slave limits
    localparam logic [12:0] FIFO_TEST_WRITES = 13'h1000;
    localparam logic [4:0]  MAX_SLAVES       = 5'h17;

    // round-trip timeout in cycles
    localparam logic [15:0] DELAY_TIMEOUT = 16'hffff;

    // uptime: one second in clocks at 125 MHz
    localparam int CLK_HZ            = 125_000_000;
    localparam int CYCLES_PER_SECOND = CLK_HZ;
    localparam logic [7:0] DAY_WRAP  = 8'hb4; // 180 days

    // receiver link status codes
    typedef enum logic [2:0] {
        link_okay_code          = 3'h0,
        downlink_fault_code     = 3'h1,
        uplink_fault_code       = 3'h2,
        reference_unlocked_code = 3'h3,
        test_switch_code        = 3'h4
    } link_code_t;

    // reset causes, numbered 1 to 11
    typedef enum logic [3:0] {
        cause_power_up    = 4'h1,
        cause_ext_line    = 4'h2,
        cause_bus_reset   = 4'h3,
        cause_op_pwr      = 4'h4,
        cause_op_rst      = 4'h5,
        cause_op_dig      = 4'h6,
        cause_boot_op     = 4'h7,
        cause_watchdog    = 4'h8,
        cause_terminal    = 4'h9,
        cause_rx_power    = 4'ha,
        cause_burn_in     = 4'hb
    } reset_cause_t;

    // control register fields
    localparam int CTRL_SWAP_CMD  = 0;
    localparam int CTRL_EXAM_CMD  = 1;
    localparam int CTRL_EXAM_QUIT = 2;
    localparam int CTRL_MON_EXIT  = 3;
    localparam int CTRL_SAVE      = 4;

endpackage

// ---- rtl/delay_meter.sv ----
// round-trip delay meter with spread
module delay_meter
    import status_diag_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // measurement
    input  wire logic             start_i,
    input  wire logic             echo_i,
    input  wire logic [7:0]       acq_period_i,
    output logic      [WIDTH-1:0] delay_o,
    output logic      [WIDTH-1:0] spread_o,
    output logic                  jitter_err_o,
    output logic                  no_sync_o,
    output logic                  done_o
);
    initial begin
        if (WIDTH < 8) $error("delay_meter WIDTH too small");
    end

    logic             busy_reg, busy_next;
    logic             first_reg, first_next;
    logic [WIDTH-1:0] cnt_reg, cnt_next;
    logic [WIDTH-1:0] dly_reg, dly_next;
    logic [WIDTH-1:0] spr_reg, spr_next;
    logic             jit_reg, jit_next;
    logic             nos_reg, nos_next;
    logic             done_reg, done_next;
    logic [WIDTH-1:0] diff;

    // next state of measurement
    always_comb begin
        busy_next  = busy_reg;
        first_next = first_reg;
        cnt_next   = cnt_reg;
        dly_next   = dly_reg;
        spr_next   = spr_reg;
        jit_next   = jit_reg;
        nos_next   = nos_reg;
        done_next  = 1'b0;
        diff       = (cnt_reg > dly_reg) ? cnt_reg - dly_reg : dly_reg - cnt_reg;
        if (start_i && !busy_reg) begin
            busy_next = 1'b1;
            cnt_next  = '0;
        end else if (busy_reg) begin
            if (echo_i) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                dly_next  = cnt_reg;
                first_next = 1'b0;
                if (!first_reg) begin
                    if (diff > spr_reg) spr_next = diff;
                    if (diff > WIDTH'({acq_period_i, 1'b0}))
                        jit_next = 1'b1;
                end
            end else if (cnt_reg == WIDTH'(DELAY_TIMEOUT)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                nos_next  = 1'b1;
            end else begin
                cnt_next = cnt_reg + WIDTH'(1);
            end
        end
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_reg  <= 1'b0;
            first_reg <= 1'b1;
            cnt_reg   <= '0;
            dly_reg   <= '0;
            spr_reg   <= '0;
            jit_reg   <= 1'b0;
            nos_reg   <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            busy_reg  <= busy_next;
            first_reg <= first_next;
            cnt_reg   <= cnt_next;
            dly_reg   <= dly_next;
            spr_reg   <= spr_next;
            jit_reg   <= jit_next;
            nos_reg   <= nos_next;
            done_reg  <= done_next;
        end
    end

    assign delay_o      = dly_reg;
    assign spread_o     = spr_reg;
    assign jitter_err_o = jit_reg;
    assign no_sync_o    = nos_reg;
    assign done_o       = done_reg;
endmodule // delay_meter

// ---- tb/status_monitor_props.sv ----
module status_monitor_props
    import status_diag_pkg::*;
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // register bus
    input wire logic [5:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic        avs_waitrequest_o,
    // status side
    input wire logic        swap_capable_i,
    input wire logic        host_out_valid_o,
    input wire logic [15:0] host_out_word_o,
    input wire logic        swap_inputs_o,
    input wire logic        beep_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // pulses, host output, swap control and read wait
    property p_beep; beep_o |=> !beep_o; endproperty
    a_beep: assert property (p_beep) else $error("beep width");
    property p_out_pulse; host_out_valid_o |=> !host_out_valid_o; endproperty
    a_out_pulse: assert property (p_out_pulse) else $error("out width");
    property p_out_cause;
        host_out_valid_o |-> $past(avs_write_i && avs_address_i == ADDR_EXAM_WRITE);
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("out cause");
    property p_out_word; host_out_valid_o |-> host_out_word_o == $past(avs_writedata_i[15:0]);
    endproperty
    a_out_word: assert property (p_out_word) else $error("out word");
    property p_swap_rise;
        $rose(swap_inputs_o) |-> $past(avs_write_i && avs_writedata_i[CTRL_SWAP_CMD]);
    endproperty
    a_swap_rise: assert property (p_swap_rise) else $error("swap set");
    property p_swap_fall;
        $fell(swap_inputs_o) |-> $past(avs_write_i) && $past(avs_address_i) == ADDR_CONTROL;
    endproperty
    a_swap_fall: assert property (p_swap_fall) else $error("swap clear");
    property p_swap_cap; $rose(swap_inputs_o) |-> $past(swap_capable_i, 3); endproperty
    a_swap_cap: assert property (p_swap_cap) else $error("swap cap");
    property p_wait; $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
    a_wait: assert property (p_wait) else $error("read wait");
endmodule // status_monitor_props

bind status_diagnostic_monitor status_monitor_props u_status_monitor_props (.*);

// ---- tb/operator_terminal.sv ----
module operator_terminal (
    // clock
    input  wire logic        clk_i,
    // avalon-mm master
    output logic      [5:0]  address_o,
    output logic             read_o,
    output logic             write_o,
    output logic      [31:0] writedata_o,
    input  wire logic [31:0] readdata_i,
    input  wire logic        waitrequest_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {address_o, read_o, write_o, writedata_o} = '0;
    // one access until waitrequest low
    task automatic access(input logic we, input logic [5:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        @(posedge clk_i);
        address_o <= a;
        writedata_o <= d;
        read_o <= !we;
        write_o <= we;
        do @(posedge clk_i); while (waitrequest_i !== 1'b0);
        q = readdata_i;
        read_o <= 1'b0;
        write_o <= 1'b0;
    endtask
endmodule // operator_terminal

// ---- tb/tb.sv ----
module tb
    import status_diag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, avs_read_i, avs_write_i, avs_waitrequest_o, fifo_full_i = 0;
    logic no_downlink_i = 0, rx_reset_fail_i = 0, test_byte_bad_i = 0, fifo_write_i = 0;
    logic fifo_test_end_i = 0, boot_reject_i = 0, slave_answer_i = 0, slave_count_done_i = 0;
    logic slave_fail_i = 0, rt_start_i = 0, rt_echo_i = 0, downlink_lost_i = 0, uplink_err_i = 0;
    logic pll_unlocked_i = 0, test_sw_off_i = 0, swap_capable_i = 1, host_session_i = 1;
    logic host_word_valid_i = 0, host_out_valid_o, swap_inputs_o, beep_o;
    logic [3:0]  reset_cause_i = 4'h8;
    logic [5:0]  avs_address_i;
    logic [7:0]  acq_period_i = 8'h04, defaults_count_i = 8'h03;
    logic [15:0] saved_version_i = 16'h000e, running_version_i = 16'h000f, host_word_i = 16'h0;
    logic [15:0] host_out_word_o, rt_delay_o;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    int errors = 0, checks_done = 0, outs = 0;
    status_diagnostic_monitor #(.SECOND_CYCLES(10)) u_status_diagnostic_monitor (.*);
    operator_terminal u_operator_terminal (.clk_i(clk_i), .address_o(avs_address_i),
        .read_o(avs_read_i), .write_o(avs_write_i), .writedata_o(avs_writedata_i),
        .readdata_i(avs_readdata_o), .waitrequest_i(avs_waitrequest_o));
    initial forever #4 clk_i = !clk_i;
    always @(posedge clk_i) outs <= outs + int'(host_out_valid_o === 1'b1);
    task automatic rd(input logic [5:0] a); u_operator_terminal.access(0, a, 32'h0, q); endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        u_operator_terminal.access(1, a, d, q);
    endtask
    task automatic wc(input logic [31:0] d); wr(ADDR_CONTROL, d); rd(ADDR_CONTROL); endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        complete_run;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_ERROR_MASK); chk("mask", 32'h0, q);
        rd(ADDR_SUMMARY); chk("summary", 32'h0003_0081, q);
        rd(ADDR_VERSION); chk("version", 32'h0000_000e, q);
        wc(32'h2); chk("ctrl", 32'h14, q);
        for (int i = 0; i < 6; i++) @(posedge clk_i) {slave_answer_i, fifo_write_i} <= {2{!i[0]}};
        for (int i = 1; i >= 0; i--) @(posedge clk_i) {no_downlink_i, rx_reset_fail_i,
            test_byte_bad_i, boot_reject_i, slave_fail_i, fifo_test_end_i,
            slave_count_done_i} <= {7{i[0]}};
        wr(ADDR_ERROR_MASK, 32'hffff_ffff);
        rd(ADDR_ERROR_MASK); chk("mask", 32'h0044_0105, q);
        rd(ADDR_SUMMARY); chk("slaves", 32'h0300, q & 32'h1f01);
        for (int i = 0; i < 4; i++) begin
            {test_sw_off_i, pll_unlocked_i, uplink_err_i, downlink_lost_i} <= 4'h1 << i;
            repeat (4) @(posedge clk_i);
            rd(ADDR_SUMMARY); chk("link", i + 1, {29'h0, q[3:1]});
        end
        {test_sw_off_i, pll_unlocked_i, uplink_err_i, downlink_lost_i} <= 4'h0;
        for (int i = 0; i < 3; i++) begin
            wc((i == 1) ? 32'h8 : 32'h1); chk("swap", {2{i != 1}}, {q[0], swap_inputs_o});
        end
        swap_capable_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        wc(32'h1); chk("refuse", 32'h9, q & 32'h19);
        wc(32'h10); chk("warn", 32'h0, q & 32'h4);
        host_session_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        wc(32'h2); chk("exam", 32'h22, q & 32'h22);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i) {host_word_valid_i, host_word_i} <= {1'b1, 16'h0064 << i};
            @(posedge clk_i) host_word_valid_i <= 1'b0;
            rd(ADDR_EXAM_WORD); chk("word", {16'(i + 1), 16'h0064 << i}, q);
        end
        wr(ADDR_EXAM_WRITE, 32'h4000);
        repeat (3) @(posedge clk_i);
        chk("outs", 32'h1, 32'(outs));
        wc(32'h4); chk("quit", 32'h0, q & 32'h2);
        acq_period_i <= 8'h02;
        @(posedge clk_i) rt_start_i <= 1'b1;
        @(posedge clk_i) rt_start_i <= 1'b0;
        repeat (5) @(posedge clk_i) rt_echo_i <= 1'b1;
        @(posedge clk_i) rt_echo_i <= 1'b0;
        chk("delay", 32'h1, 32'(rt_delay_o));
        complete_run;
    end
endmodule // tb
